// ### design/rtcv_pkg.sv
/*
  Constants shared by the event, interrupt-mask and data-validity logic
  of the real-time clock. Assumes nothing beyond a SystemVerilog tool.
*/
`default_nettype none

package rtcv_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_EVENT_FLAGS   = 8'h18;
  localparam logic [7:0] OFS_EVENT_CLEAR   = 8'h1C;
  localparam logic [7:0] OFS_IRQ_SET       = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR     = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK      = 8'h28;
  localparam logic [7:0] OFS_VALIDITY      = 8'h2C;
  localparam logic [7:0] OFS_TEV_SELECT    = 8'h30;

  // ----------------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------------
  localparam int NUM_EVT     = 5;
  localparam int BIT_UPD_ACK = 0;
  localparam int BIT_ALARM   = 1;
  localparam int BIT_SECOND  = 2;
  localparam int BIT_TIME_EV = 3;
  localparam int BIT_CAL_EV  = 4;
  localparam int NUM_VALID   = 4;
  localparam int BIT_TSEL_LO = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [NUM_EVT-1:0]   FLAGS_RST = 5'h00;
  localparam logic [NUM_EVT-1:0]   MASK_RST  = 5'h00;
  localparam logic [NUM_VALID-1:0] VALID_RST = 4'h0;

  // ----------------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Source of the time event flag, in select-field order
  typedef enum logic [1:0] {
    TEV_MINUTE,
    TEV_HOUR,
    TEV_NOON,
    TEV_MIDNIGHT
  } rtcv_tev_e;

  // Which clock register a checked word belongs to; order = validity bit
  typedef enum logic [1:0] {
    CHK_TIME,
    CHK_CALENDAR,
    CHK_TIME_ALARM,
    CHK_CAL_ALARM
  } rtcv_chk_e;

endpackage : rtcv_pkg

`default_nettype wire

// ### design/rtcv_chk_if.sv
/*
  Carrier between the validity tracker and the field range checker.
  Assumes the checker answers combinationally in the same cycle.
*/
`timescale 1ns/1ns
`default_nettype none

interface rtcv_chk_if;
  import rtcv_pkg::*;
  logic [31:0] word;     // Word written to a clock register
  rtcv_chk_e   kind;     // Register it was written to
  logic        mode24;   // Hour mode, high for 24-hour
  logic        invalid;  // Some field out of its legal range

  modport req (output word, output kind, output mode24, input invalid);
  modport chk (input word, input kind, input mode24, output invalid);
endinterface : rtcv_chk_if

`default_nettype wire

// ### design/rtcv_bcd_check.sv
/*
  Range checker for words written to the time, calendar and alarm
  registers. Purely combinational; assumes fields laid out as in the
  clock's time, calendar and alarm registers.
*/
`timescale 1ns/1ns
`default_nettype none

module rtcv_bcd_check
  import rtcv_pkg::*;
(
  rtcv_chk_if.chk chk
);

  // Both digits decimal and value within [lo, hi]; BCD keeps order
  function automatic logic bcd_in(input logic [7:0] v,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    bcd_in = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  // ----------------------------------------------------------------------
  // Per-kind field checks
  // ----------------------------------------------------------------------
  logic hour_ok;
  logic alm_hour_ok;
  logic ok;

  // Hour legality depends on the 12/24 hour mode; pm bit only in 12h
  always_comb begin
    if (chk.mode24) begin
      hour_ok = bcd_in({2'h0, chk.word[21:16]}, 8'h00, 8'h23) &&
                !chk.word[22];
    end else begin
      hour_ok = bcd_in({2'h0, chk.word[21:16]}, 8'h01, 8'h12);
    end
    // An alarm field that is not enabled never compares, so skip it
    alm_hour_ok = !chk.word[23] || hour_ok;
  end

  // Select the check by register
  always_comb begin
    case (chk.kind)
      CHK_TIME: begin
        ok = bcd_in({1'h0, chk.word[6:0]}, 8'h00, 8'h59) &&
             bcd_in({1'h0, chk.word[14:8]}, 8'h00, 8'h59) && hour_ok;
      end
      CHK_CALENDAR: begin
        ok = bcd_in({1'h0, chk.word[6:0]}, 8'h19, 8'h20) &&
             bcd_in(chk.word[15:8], 8'h00, 8'h99) &&
             bcd_in({3'h0, chk.word[20:16]}, 8'h01, 8'h12) &&
             bcd_in({5'h00, chk.word[23:21]}, 8'h01, 8'h07) &&
             bcd_in({2'h0, chk.word[29:24]}, 8'h01, 8'h31);
      end
      CHK_TIME_ALARM: begin
        ok = (!chk.word[7] ||
              bcd_in({1'h0, chk.word[6:0]}, 8'h00, 8'h59)) &&
             (!chk.word[15] ||
              bcd_in({1'h0, chk.word[14:8]}, 8'h00, 8'h59)) &&
             alm_hour_ok;
      end
      CHK_CAL_ALARM: begin
        ok = (!chk.word[23] ||
              bcd_in({3'h0, chk.word[20:16]}, 8'h01, 8'h12)) &&
             (!chk.word[31] ||
              bcd_in({2'h0, chk.word[29:24]}, 8'h01, 8'h31));
      end
      default: begin
        ok = 1'b1;
      end
    endcase
  end

  assign chk.invalid = !ok;

endmodule : rtcv_bcd_check

`default_nettype wire

// ### design/rtcv_top.sv
/*
  Event flags, interrupt mask and data-validity register of the real-time
  clock, reached over AXI4-Lite. Assumes the counters, alarm comparator
  and clock register file run on the same clock and hand over one-cycle
  event pulses and write strobes with the written word.
*/
`timescale 1ns/1ns
`default_nettype none

module rtcv_top
  import rtcv_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Event pulses from the counters and the alarm comparator
  input  wire logic              update_acknowledge_evt,
  input  wire logic              alarm_match_evt,
  input  wire logic              second_evt,
  input  wire logic              minute_evt,
  input  wire logic              hour_evt,
  input  wire logic              noon_evt,
  input  wire logic              midnight_evt,
  input  wire logic              calendar_event_evt,
  // Write strobes of the clock registers, with the word written
  input  wire logic              time_register_wr,
  input  wire logic              calendar_register_wr,
  input  wire logic              time_alarm_register_wr,
  input  wire logic              calendar_alarm_register_wr,
  input  wire logic [31:0]       clock_reg_wdata,
  input  wire logic              hour_mode_24,
  // Interrupt request and the chosen time event source
  output logic                   irq,
  output logic [1:0]             time_event_select
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // Every offset, including the highest, must be reachable
  generate
    if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
      $error("rtcv_top: ADDR_W must lie in 6 to 32");
    end
  endgenerate

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic              awready_ff;
  logic              wready_ff;
  logic              aw_got_ff;
  logic              w_got_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0]       w_data_ff;
  logic              w_lane0_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              arready_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;

  logic [NUM_EVT-1:0]   flags_ff;
  logic [NUM_EVT-1:0]   mask_ff;
  logic [NUM_VALID-1:0] valid_ff;
  rtcv_tev_e            tev_sel_ff;
  logic                 irq_ff;

  logic [NUM_EVT-1:0]   nxt_flags;
  logic [NUM_EVT-1:0]   nxt_mask;
  logic [NUM_EVT-1:0]   evt_set;
  logic [NUM_EVT-1:0]   evt_clr;
  logic                 tev_pulse;
  logic                 wr_go;
  logic                 wr_hit;
  logic                 rd_hit;
  logic [31:0]          rd_word;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  // Word-aligned match; the low two address bits are ignored
  function automatic logic at(input logic [ADDR_W-1:0] a,
                              input logic [7:0]        ofs);
    logic [ADDR_W-1:0] wide;
    wide = ADDR_W'(ofs);
    at   = (a[ADDR_W-1:2] == wide[ADDR_W-1:2]);
  endfunction

  // Write effects need both address and data held and no answer pending
  assign wr_go = aw_got_ff && w_got_ff && !bvalid_ff;

  // Known offsets; writes to read-only ones are taken and ignored
  always_comb begin
    wr_hit = at(aw_addr_ff, OFS_EVENT_FLAGS) ||
             at(aw_addr_ff, OFS_EVENT_CLEAR) ||
             at(aw_addr_ff, OFS_IRQ_SET) ||
             at(aw_addr_ff, OFS_IRQ_CLEAR) ||
             at(aw_addr_ff, OFS_IRQ_MASK) ||
             at(aw_addr_ff, OFS_VALIDITY) ||
             at(aw_addr_ff, OFS_TEV_SELECT);
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------------
  // Address and data are captured independently, in either order
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      awready_ff <= 1'b1;
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_got_ff  <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_got_ff  <= 1'b0;
    end else if (bvalid_ff && s_axi_bready) begin
      awready_ff <= 1'b1; // Reopen only once the answer is gone
    end
  end

  // Data side mirrors the address side
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wready_ff  <= 1'b1;
      w_got_ff   <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_lane0_ff <= 1'b0;
    end else if (s_axi_wvalid && wready_ff) begin
      wready_ff  <= 1'b0;
      w_got_ff   <= 1'b1;
      w_data_ff  <= s_axi_wdata;
      w_lane0_ff <= s_axi_wstrb[0];
    end else if (wr_go) begin
      w_got_ff   <= 1'b0;
    end else if (bvalid_ff && s_axi_bready) begin
      wready_ff  <= 1'b1;
    end
  end

  // Response one cycle after both halves are held
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channels
  // ----------------------------------------------------------------------
  // Write-only registers read as zero; unmapped addresses answer SLVERR
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    if (at(s_axi_araddr, OFS_EVENT_FLAGS)) begin
      rd_word[NUM_EVT-1:0] = flags_ff;
    end else if (at(s_axi_araddr, OFS_IRQ_MASK)) begin
      rd_word[NUM_EVT-1:0] = mask_ff;
    end else if (at(s_axi_araddr, OFS_VALIDITY)) begin
      rd_word[NUM_VALID-1:0] = valid_ff;
    end else if (at(s_axi_araddr, OFS_TEV_SELECT)) begin
      rd_word[BIT_TSEL_LO +: 2] = tev_sel_ff;
    end else if (!(at(s_axi_araddr, OFS_EVENT_CLEAR) ||
                   at(s_axi_araddr, OFS_IRQ_SET) ||
                   at(s_axi_araddr, OFS_IRQ_CLEAR))) begin
      rd_hit = 1'b0;
    end
  end

  // One read in flight; the address is taken only when no data waits
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= rd_word;
      rresp_ff   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------------
  // Only the chosen source may raise the time event
  always_comb begin
    case (tev_sel_ff)
      TEV_MINUTE:   tev_pulse = minute_evt;
      TEV_HOUR:     tev_pulse = hour_evt;
      TEV_NOON:     tev_pulse = noon_evt;
      TEV_MIDNIGHT: tev_pulse = midnight_evt;
      default:      tev_pulse = 1'b0;
    endcase
  end

  // Sources and clears per bit; a set in the clear cycle wins
  always_comb begin
    evt_set = '0;
    evt_clr = '0;
    evt_set[BIT_UPD_ACK] = update_acknowledge_evt;
    evt_set[BIT_ALARM]   = alarm_match_evt;
    evt_set[BIT_SECOND]  = second_evt;
    evt_set[BIT_TIME_EV] = tev_pulse;
    evt_set[BIT_CAL_EV]  = calendar_event_evt;
    if (wr_go && w_lane0_ff && at(aw_addr_ff, OFS_EVENT_CLEAR)) begin
      evt_clr[BIT_UPD_ACK] = w_data_ff[BIT_UPD_ACK];
      evt_clr[BIT_ALARM]   = w_data_ff[BIT_ALARM];
      evt_clr[BIT_SECOND]  = w_data_ff[BIT_SECOND];
      evt_clr[BIT_TIME_EV] = w_data_ff[BIT_TIME_EV];
      evt_clr[BIT_CAL_EV]  = w_data_ff[BIT_CAL_EV];
    end
    nxt_flags = (flags_ff & ~evt_clr) | evt_set;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      flags_ff <= FLAGS_RST;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt mask and request
  // ----------------------------------------------------------------------
  // Separate set and clear registers avoid read-modify-write races
  always_comb begin
    nxt_mask = mask_ff;
    if (wr_go && w_lane0_ff && at(aw_addr_ff, OFS_IRQ_SET)) begin
      nxt_mask = mask_ff | w_data_ff[NUM_EVT-1:0];
    end else if (wr_go && w_lane0_ff && at(aw_addr_ff, OFS_IRQ_CLEAR)) begin
      nxt_mask = mask_ff & ~w_data_ff[NUM_EVT-1:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mask_ff <= MASK_RST;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // Registered from next values, so the request moves with the flags
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_flags & nxt_mask);
    end
  end

  // ----------------------------------------------------------------------
  // Time event source select
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tev_sel_ff <= TEV_MINUTE;
    end else if (wr_go && w_lane0_ff && at(aw_addr_ff, OFS_TEV_SELECT)) begin
      tev_sel_ff <= rtcv_tev_e'(w_data_ff[BIT_TSEL_LO +: 2]);
    end
  end

  // ----------------------------------------------------------------------
  // Data validity
  // ----------------------------------------------------------------------
  rtcv_chk_if chk_bus ();

  // The clock register file writes one register at a time; time first
  always_comb begin
    chk_bus.word   = clock_reg_wdata;
    chk_bus.mode24 = hour_mode_24;
    if (time_register_wr) begin
      chk_bus.kind = CHK_TIME;
    end else if (calendar_register_wr) begin
      chk_bus.kind = CHK_CALENDAR;
    end else if (time_alarm_register_wr) begin
      chk_bus.kind = CHK_TIME_ALARM;
    end else begin
      chk_bus.kind = CHK_CAL_ALARM;
    end
  end

  rtcv_bcd_check u_check (
    .chk (chk_bus.chk)
  );

  // Each bit holds the verdict on its register's latest write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      valid_ff <= VALID_RST;
    end else if (time_register_wr) begin
      valid_ff[CHK_TIME] <= chk_bus.invalid;
    end else if (calendar_register_wr) begin
      valid_ff[CHK_CALENDAR] <= chk_bus.invalid;
    end else if (time_alarm_register_wr) begin
      valid_ff[CHK_TIME_ALARM] <= chk_bus.invalid;
    end else if (calendar_alarm_register_wr) begin
      valid_ff[CHK_CAL_ALARM] <= chk_bus.invalid;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready     = awready_ff;
  assign s_axi_wready      = wready_ff;
  assign s_axi_bvalid      = bvalid_ff;
  assign s_axi_bresp       = bresp_ff;
  assign s_axi_arready     = arready_ff;
  assign s_axi_rvalid      = rvalid_ff;
  assign s_axi_rdata       = rdata_ff;
  assign s_axi_rresp       = rresp_ff;
  assign irq               = irq_ff;
  assign time_event_select = tev_sel_ff;

endmodule : rtcv_top

`default_nettype wire

// ### verif/rtcv_checker.sv
/* Bus and interrupt checker for rtcv_top.
   Assumes binding to rtcv_top; sees its ports only. */
`timescale 1ns/1ns
`default_nettype none
module rtcv_checker
  import rtcv_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq,
  input wire logic [1:0]  time_event_select
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Both halves taken together: answer two edges later
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_write_busy: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  a_write_free: assert property (s_axi_bvalid && s_axi_bready
    |=> s_axi_awready && s_axi_wready) else $error("ready not back");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while busy");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 32'h0000_0000) else $error("error data");
  // Only a clear or disable write can drop the request
  a_irq_drop: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("irq dropped without write");
  a_select_held: assert property (!$rose(s_axi_bvalid)
    |-> $stable(time_event_select)) else $error("select moved");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_irq: cover property ($rose(irq));
endmodule // rtcv_checker
bind rtcv_top rtcv_checker i_rtcv_checker (.*);
`default_nettype wire

// ### verif/test_rtcv_top.sv
/* Self-checking bench for rtcv_top.
   Assumes the bench alone drives every input. */
`timescale 1ns/1ns
`default_nettype none
module test_rtcv_top;
  import rtcv_pkg::*;
  logic        clock = 0, reset_n = 0, h24 = 1;
  logic [7:0]  awaddr = 0, araddr = 0, ev = 0;
  logic [31:0] wdata = 0, cwd = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [3:0]  vs = 0, ws = 4'hf;
  wire logic   awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]  bresp, rresp, tsel;
  wire logic [31:0] rdata;
  int          error_cnt = 0, n_checks = 0, cyc = 0;
  always #5 clock = ~clock;
  rtcv_top i_rtcv_top (.clock(clock), .reset_n(reset_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .update_acknowledge_evt(ev[0]), .alarm_match_evt(ev[1]),
    .second_evt(ev[2]), .minute_evt(ev[3]), .hour_evt(ev[5]),
    .noon_evt(ev[6]), .midnight_evt(ev[7]), .calendar_event_evt(ev[4]),
    .time_register_wr(vs[0]), .calendar_register_wr(vs[1]),
    .time_alarm_register_wr(vs[2]), .calendar_alarm_register_wr(vs[3]),
    .clock_reg_wdata(cwd), .hour_mode_24(h24), .irq(irq),
    .time_event_select(tsel));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write: both halves offered at once, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    @(posedge clock);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    forever begin
      @(posedge clock);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] er = RESP_OKAY);
    @(posedge clock);
    araddr <= a; arvalid <= 1; rready <= 1;
    forever begin
      @(posedge clock);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    rready <= 0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // One-cycle event pulse; flag lands on the second edge
  task automatic pulse(input logic [7:0] b);
    @(posedge clock); ev <= b;
    @(posedge clock); ev <= 0;
    #1;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_reset;
    rdc(OFS_IRQ_MASK, 0);
    rdc(OFS_VALIDITY, 0);
    rdc(OFS_EVENT_FLAGS, 0);
    chk(tsel, 0);
    rdc(8'h40, 0, RESP_SLVERR);
    wr(8'h40, 32'h1f, RESP_SLVERR);
    wr(OFS_IRQ_MASK, 32'h1f); // Read-only place ignores the write
    rdc(OFS_IRQ_MASK, 0);
  endtask
  task automatic s_mask;
    wr(OFS_IRQ_SET, 32'h15); rdc(OFS_IRQ_MASK, 32'h15);
    wr(OFS_IRQ_SET, 32'h0a); rdc(OFS_IRQ_MASK, 32'h1f);
    wr(OFS_IRQ_CLEAR, 32'h05); rdc(OFS_IRQ_MASK, 32'h1a);
    wr(OFS_IRQ_CLEAR, 32'h1a); rdc(OFS_IRQ_MASK, 32'h00);
    // Low byte lane disabled: the write is answered but has no effect
    ws <= 4'h0;
    wr(OFS_IRQ_SET, 32'h1f);
    ws <= 4'hf;
    rdc(OFS_IRQ_MASK, 32'h00);
  endtask
  task automatic s_flags;
    logic [31:0] b;
    wr(OFS_IRQ_SET, 32'h1f);
    for (int i = 0; i < 5; i++) begin
      b = 32'h1 << i;
      pulse(b[7:0]);
      chk(irq, 1);
      rdc(OFS_EVENT_FLAGS, b);
      wr(OFS_EVENT_CLEAR, ~b & 32'h1f);
      rdc(OFS_EVENT_FLAGS, b);
      wr(OFS_EVENT_CLEAR, b);
      rdc(OFS_EVENT_FLAGS, 0);
      chk(irq, 0);
    end
    // Masked source must not raise the request
    wr(OFS_IRQ_CLEAR, 32'h1f);
    pulse(8'h04);
    chk(irq, 0);
    wr(OFS_EVENT_CLEAR, 32'h04);
  endtask
  task automatic s_tsel;
    logic [7:0] sb;
    for (int s = 0; s < 4; s++) begin
      sb = (s == 0) ? 8'h08 : (8'h10 << s);
      wr(OFS_TEV_SELECT, s);
      chk(tsel, s);
      pulse(8'he8 ^ sb);
      rdc(OFS_EVENT_FLAGS, 0);
      pulse(sb);
      rdc(OFS_EVENT_FLAGS, 32'h08);
      wr(OFS_EVENT_CLEAR, 32'h08);
    end
    wr(OFS_TEV_SELECT, 0);
  endtask
  // Invalid words stick per register; valid rewrite clears its bit
  task automatic vwr(input int k, input logic [31:0] w);
    @(posedge clock); cwd <= w; vs <= 4'h1 << k;
    @(posedge clock); vs <= 0;
  endtask
  task automatic s_valid;
    logic [31:0] bad [4];
    logic [31:0] good [4];
    logic [31:0] e;
    bad = '{32'h0000_005a, 32'h0000_0000, 32'h0000_00da, 32'h8000_0000};
    good = '{32'h0012_3045, 32'h0181_9819, 32'h0000_0000, 32'h0000_0000};
    e = 0;
    for (int k = 0; k < 4; k++) begin
      vwr(k, bad[k]); e[k] = 1;
      rdc(OFS_VALIDITY, e);
    end
    for (int k = 0; k < 4; k++) begin
      vwr(k, good[k]); e[k] = 0;
      rdc(OFS_VALIDITY, e);
    end
    // 12-hour mode: hour 00 is illegal, pm 12 is legal
    h24 <= 0;
    vwr(0, 32'h0000_0000);
    rdc(OFS_VALIDITY, 32'h1);
    vwr(0, 32'h0052_0000);
    rdc(OFS_VALIDITY, 32'h0);
    h24 <= 1;
  endtask
  // ------------------------------------------------------------
  // Sequence and hang guard
  // ------------------------------------------------------------
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1;
    s_reset;
    s_mask;
    s_flags;
    s_tsel;
    s_valid;
    stop_test;
  end
endmodule // test_rtcv_top
`default_nettype wire
